// [src/sts_sequencer.sv]
/*
  Three-layer arm / scan / channel trigger sequencer.
  Assumes all event inputs are one-cycle pulses synchronous to clk_sys,
  and that configuration ports are held stable while not idle.
*/
// Function
// - Armed indicator is off whenever the sequencer is idle.
// - Step key or initiate commands leave idle, light armed, enter arm layer.
// - Immediate arm spacing goes straight to the scan layer.
// - Manual arm spacing waits for the step key.
// - Bus arm spacing waits for a bus trigger.
// - External arm spacing waits for an external trigger pulse.
// - Link arm spacing waits for a trigger link input.
// - Arm count 1 to 9999 or infinite; re-arm while arms remain.
// - A satisfied arm layer advances into the scan layer.
// - Immediate scan spacing passes to the channel layer at once.
// - Other scan spacings wait in the scan layer for their event.
// - Timer scan spacing passes first scan at once, later ones on expiry.
// - Spacing timer interval is 1 ms to 99999.999 s.
// - Scan count 1 to 9999 or infinite.
// - A satisfied scan layer advances into the channel layer.
// - Immediate channel spacing scans each channel at once.
// - Other channel spacings wait for their event before each channel.
// - Timer channel spacing scans first channel at once, rest on expiry.
// - Channel count defaults to list length; also 1 to 9999 or infinite.
// - Each step opens the previous channel, closes next; list wraps.
// - Open-all aborts, opens every channel, returns idle with armed off.
// - Per-slot settling delay follows each channel closure.
`timescale 1ns/1ps
`default_nettype none

module sts_sequencer #(
  parameter int LIST_DEPTH = 40,
  parameter int CHAN_W     = 6
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      step_key,
  input  wire logic                      initiate_command,
  input  wire logic                      continuous_initiate_command,
  input  wire logic                      bus_trigger,
  input  wire logic                      ext_trigger,
  input  wire logic                      link_trigger,
  input  wire logic                      open_all,
  input  wire sts_pkg::sts_spacing_t     arm_spacing,
  input  wire sts_pkg::sts_spacing_t     scan_spacing,
  input  wire sts_pkg::sts_spacing_t     chan_spacing,
  input  wire logic [13:0]               arm_count,
  input  wire logic                      arm_infinite,
  input  wire logic [13:0]               scan_count,
  input  wire logic                      scan_infinite,
  input  wire logic [13:0]               chan_count,
  input  wire logic                      chan_infinite,
  input  wire logic                      chan_use_list,
  input  wire logic [CHAN_W-1:0]         list_len,
  input  wire logic [26:0]               timer_ms,
  input  wire logic [26:0]               settle_ms,
  output logic                           armed,
  output logic                           chan_valid,
  output logic [CHAN_W-1:0]              chan_closed,
  output logic                           open_all_pulse,
  output logic                           cfg_error
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (LIST_DEPTH < 1 || LIST_DEPTH >= (1 << CHAN_W)) begin : g_chk
    $error("LIST_DEPTH does not fit CHAN_W");
  end

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_ARM    = 6'h02,
    ST_SCAN   = 6'h04,
    ST_CHAN   = 6'h08,
    ST_SETTLE = 6'h10
  } sts_state_t;

  sts_state_t        state_r;
  sts_state_t        state_nxt;
  logic [13:0]       arms_done_r;
  logic [13:0]       scans_done_r;
  logic [13:0]       chans_done_r;
  logic [CHAN_W-1:0] idx_r;
  logic              first_scan_r;
  logic              first_chan_r;
  logic [26:0]       tmr_ms_r;
  logic [26:0]       set_ms_r;
  logic [15:0]       tick_cnt_r;
  logic              tick;
  logic              leave_idle;
  logic              arm_go;
  logic              scan_go;
  logic              chan_go;
  logic              tmr_done;
  logic              arm_last;
  logic              scan_last;
  logic              chan_last;
  logic [13:0]       chan_lim;

  // ----------------------------------------------------------------------
  // Event selection
  // ----------------------------------------------------------------------
  function automatic logic sel_event(input sts_pkg::sts_spacing_t sp,
                                     input logic tmr_ok);
    unique case (sp)
      sts_pkg::STS_SP_IMMED: sel_event = 1'b1;
      sts_pkg::STS_SP_TIMER: sel_event = tmr_ok;
      sts_pkg::STS_SP_EXT:   sel_event = ext_trigger;
      sts_pkg::STS_SP_BUS:   sel_event = bus_trigger;
      sts_pkg::STS_SP_MAN:   sel_event = step_key;
      sts_pkg::STS_SP_LINK:  sel_event = link_trigger;
      default:               sel_event = 1'b0;
    endcase
  endfunction : sel_event

  // Arm timer spacing has no documented meaning; it is treated as immediate.
  assign leave_idle = step_key | initiate_command
                    | continuous_initiate_command;
  assign arm_go  = (arm_spacing == sts_pkg::STS_SP_TIMER) ? 1'b1 :
                   sel_event(arm_spacing, 1'b0);
  assign tmr_done = (tmr_ms_r == 27'h0000000);
  assign scan_go = sel_event(scan_spacing,
                             first_scan_r | tmr_done);
  assign chan_go = sel_event(chan_spacing,
                             first_chan_r | tmr_done);
  assign chan_lim = chan_use_list ? {{(14-CHAN_W){1'b0}}, list_len}
                                  : chan_count;
  assign arm_last  = !arm_infinite  && (arms_done_r + 14'h0001 >= arm_count);
  assign scan_last = !scan_infinite && (scans_done_r + 14'h0001 >= scan_count);
  assign chan_last = !(chan_infinite && !chan_use_list)
                   && (chans_done_r + 14'h0001 >= chan_lim);
  assign cfg_error = (timer_ms < sts_pkg::STS_TMR_MIN_MS)
                   || (timer_ms > sts_pkg::STS_TMR_MAX_MS)
                   || (!arm_infinite && arm_count > sts_pkg::STS_CNT_MAX)
                   || (!scan_infinite && scan_count > sts_pkg::STS_CNT_MAX)
                   || (list_len == '0);

  // ----------------------------------------------------------------------
  // Layer sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:   if (leave_idle) state_nxt = ST_ARM;
      ST_ARM:    if (arm_go) state_nxt = ST_SCAN;
      ST_SCAN:   if (scan_go) state_nxt = ST_CHAN;
      ST_CHAN:   if (chan_go) state_nxt = ST_SETTLE;
      ST_SETTLE: begin
        if (set_ms_r == 27'h0000000) begin
          if (!chan_last) state_nxt = ST_CHAN;
          else if (!scan_last) state_nxt = ST_SCAN;
          else if (!arm_last) state_nxt = ST_ARM;
          else state_nxt = ST_IDLE;
        end
      end
      default:   state_nxt = ST_IDLE;
    endcase
    if (open_all) state_nxt = ST_IDLE;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) armed <= 1'b0;
    else armed <= (state_nxt != ST_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) open_all_pulse <= 1'b0;
    else open_all_pulse <= open_all && (state_r != ST_IDLE);
  end

  // ----------------------------------------------------------------------
  // Layer counters
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || state_r == ST_IDLE) begin
      arms_done_r  <= '0;
      scans_done_r <= '0;
      chans_done_r <= '0;
    end else if (state_r == ST_SETTLE && set_ms_r == 27'h0000000) begin
      if (!chan_last) begin
        chans_done_r <= chans_done_r + 14'h0001;
      end else begin
        chans_done_r <= '0;
        if (!scan_last) begin
          scans_done_r <= scans_done_r + 14'h0001;
        end else begin
          scans_done_r <= '0;
          arms_done_r  <= arms_done_r + 14'h0001;
        end
      end
    end
  end

  // First pass flags: the first scan of an arm and the first channel of a
  // scan go at once under timer spacing.
  always_ff @(posedge clk_sys) begin
    if (rst || state_r == ST_IDLE || state_r == ST_ARM) first_scan_r <= 1'b1;
    else if (state_r == ST_SCAN && scan_go) first_scan_r <= 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (rst || state_r == ST_SCAN || state_r == ST_IDLE) first_chan_r <= 1'b1;
    else if (state_r == ST_CHAN && chan_go) first_chan_r <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Millisecond tick, spacing timer and settling delay
  // ----------------------------------------------------------------------
  assign tick = (tick_cnt_r == 16'(sts_pkg::STS_TICK_CYC - 1));

  always_ff @(posedge clk_sys) begin
    if (rst || tick) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_cnt_r + 16'h0001;
  end

  // One timer serves both layers; it restarts on each scan or channel
  // event, so tick phase adds at most one millisecond of jitter.
  always_ff @(posedge clk_sys) begin
    if (rst || state_r == ST_IDLE) tmr_ms_r <= '0;
    else if ((state_r == ST_SCAN && scan_go) || (state_r == ST_CHAN && chan_go))
      tmr_ms_r <= timer_ms;
    else if (tick && !tmr_done) tmr_ms_r <= tmr_ms_r - 27'h0000001;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) set_ms_r <= '0;
    else if (state_r == ST_CHAN && chan_go) set_ms_r <= settle_ms;
    else if (tick && set_ms_r != 27'h0000000) set_ms_r <= set_ms_r - 27'h0000001;
  end

  // ----------------------------------------------------------------------
  // Channel list walk
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) idx_r <= sts_pkg::STS_LIST_RST[CHAN_W-1:0];
    else if (state_r == ST_IDLE) idx_r <= sts_pkg::STS_LIST_RST[CHAN_W-1:0];
    else if (state_r == ST_CHAN && chan_go) begin
      if (idx_r >= list_len) idx_r <= CHAN_W'(1);
      else idx_r <= idx_r + CHAN_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || open_all) begin
      chan_valid  <= 1'b0;
      chan_closed <= sts_pkg::STS_CHAN_RST[CHAN_W-1:0];
    end else if (state_r == ST_CHAN && chan_go) begin
      chan_valid  <= 1'b1;
      chan_closed <= (idx_r > list_len) ? CHAN_W'(1) : idx_r;
    end
  end

endmodule : sts_sequencer

`default_nettype wire

// [src/sts_pkg.sv]
/*
  Package for the scan trigger sequencer: spacing source codes, count
  limits and timing constants.
  Assumes a 50 MHz system clock; nothing else.
*/
package sts_pkg;

  // ----------------------------------------------------------------------
  // Spacing sources
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    STS_SP_IMMED = 3'h0,
    STS_SP_TIMER = 3'h1,
    STS_SP_EXT   = 3'h2,
    STS_SP_BUS   = 3'h3,
    STS_SP_MAN   = 3'h4,
    STS_SP_LINK  = 3'h5
  } sts_spacing_t;

  // ----------------------------------------------------------------------
  // Counts and timing
  // ----------------------------------------------------------------------
  localparam int          STS_CNT_W      = 14;
  localparam logic [13:0] STS_CNT_MIN    = 14'h0001;
  localparam logic [13:0] STS_CNT_MAX    = 14'h270F;
  localparam int          STS_CLK_HZ     = 50000000;
  localparam int          STS_TICK_US    = 1000;
  localparam int          STS_TICK_CYC   = STS_CLK_HZ / 1000000 * STS_TICK_US;
  localparam int          STS_TMR_W      = 27;
  localparam logic [26:0] STS_TMR_MAX_MS = 27'h5F5E0FF;
  localparam logic [26:0] STS_TMR_MIN_MS = 27'h0000001;
  localparam logic [5:0]  STS_LIST_RST   = 6'h01;
  localparam logic [5:0]  STS_CHAN_RST   = 6'h00;

endpackage : sts_pkg

// [testbench/sts_sequencer_checker.sv]
/* Port checker for the sequencer: start, abort and channel output.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module sts_sequencer_checker #(parameter int CHAN_W = 6) (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  step_key,
  input wire logic                  initiate_command,
  input wire logic                  continuous_initiate_command,
  input wire logic                  open_all,
  input wire sts_pkg::sts_spacing_t arm_spacing,
  input wire sts_pkg::sts_spacing_t scan_spacing,
  input wire sts_pkg::sts_spacing_t chan_spacing,
  input wire logic [CHAN_W-1:0]     list_len,
  input wire logic                  armed,
  input wire logic                  chan_valid,
  input wire logic [CHAN_W-1:0]     chan_closed,
  input wire logic                  open_all_pulse,
  input wire logic                  cfg_error
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_go;
    !armed && step_key && !open_all && !cfg_error &&
    arm_spacing == sts_pkg::STS_SP_IMMED &&
    scan_spacing == sts_pkg::STS_SP_IMMED &&
    chan_spacing == sts_pkg::STS_SP_IMMED;
  endsequence
  sequence s_close;
    ##1 armed ##3 chan_valid;
  endsequence
  wire logic start = step_key | initiate_command | continuous_initiate_command;
  a_idle_stays_off: assert property (!armed && !start |=> !armed)
    else $error("armed rose without a start");
  a_start_arms: assert property (!armed && start && !open_all && !cfg_error
    |=> armed) else $error("start did not arm");
  a_immed_close: assert property (s_go |-> s_close)
    else $error("immediate run did not close a channel in time");
  a_abort_idle: assert property (armed && open_all |=> !armed && !chan_valid)
    else $error("abort left the sequencer busy");
  a_abort_pulse: assert property (armed && open_all
    |=> open_all_pulse ##1 !open_all_pulse)
    else $error("abort pulse wrong");
  a_pulse_cause: assert property (open_all_pulse
    |-> $past(open_all) && $past(armed))
    else $error("abort pulse without request");
  a_chan_range: assert property (chan_valid |-> chan_closed >= 1 &&
    chan_closed <= list_len) else $error("channel index out of list");
  a_chan_hold: assert property ($changed(chan_closed)
    |-> $past(armed) || $past(open_all))
    else $error("channel moved while idle");
endmodule : sts_sequencer_checker
bind sts_sequencer sts_sequencer_checker #(.CHAN_W(CHAN_W)) u_chk (.clk_sys,
  .rst, .step_key, .initiate_command, .continuous_initiate_command,
  .open_all, .arm_spacing, .scan_spacing, .chan_spacing, .list_len, .armed,
  .chan_valid, .chan_closed, .open_all_pulse, .cfg_error);
`default_nettype wire

// [testbench/sts_src_model.sv]
/* Far side: step key, bus controller and trigger inputs.
   Assumes go is raised by the bench away from the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module sts_src_model (
  input  wire logic                  clk_sys,
  input  wire logic                  go,
  input  wire sts_pkg::sts_spacing_t src,
  output logic                       step_key,
  output logic                       bus_trigger,
  output logic                       ext_trigger,
  output logic                       link_trigger
);
  // Pulses launch just after a rising edge so the design sees them whole.
  always @(posedge clk_sys) begin
    step_key     <= go && src == sts_pkg::STS_SP_MAN;
    bus_trigger  <= go && src == sts_pkg::STS_SP_BUS;
    ext_trigger  <= go && src == sts_pkg::STS_SP_EXT;
    link_trigger <= go && src == sts_pkg::STS_SP_LINK;
  end
endmodule : sts_src_model
`default_nettype wire

// [testbench/testbench.sv]
/* Bench for the sequencer: start, spacing, count and abort runs.
   Assumes the source model delivers trigger pulses on request. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys, rst, key, initiate_command, continuous_initiate_command;
  logic open_all, go, arm_infinite, scan_infinite, chan_infinite;
  logic chan_use_list;
  sts_pkg::sts_spacing_t arm_spacing, scan_spacing, chan_spacing, src, sp;
  logic [13:0] arm_count, scan_count, chan_count;
  logic [5:0]  list_len, pc, c1;
  logic [26:0] timer_ms, settle_ms;
  wire logic st_m, bus_trigger, ext_trigger, link_trigger, armed;
  wire logic chan_valid, open_all_pulse, cfg_error;
  wire logic [5:0] chan_closed;
  wire logic step_key = key | st_m;
  int fails, compares, cyc, n;
  sts_sequencer u_sts_sequencer (.clk_sys, .rst, .step_key,
    .initiate_command, .continuous_initiate_command, .bus_trigger,
    .ext_trigger, .link_trigger, .open_all, .arm_spacing, .scan_spacing,
    .chan_spacing, .arm_count, .arm_infinite, .scan_count, .scan_infinite,
    .chan_count, .chan_infinite, .chan_use_list, .list_len, .timer_ms,
    .settle_ms, .armed, .chan_valid, .chan_closed, .open_all_pulse,
    .cfg_error);
  sts_src_model u_sts_src_model (.clk_sys, .go, .src, .step_key(st_m),
    .bus_trigger, .ext_trigger, .link_trigger);
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Closures are counted as changes of the closed index, sampled off the
  // launching edge so the registered output has settled.
  always @(negedge clk_sys) begin
    cyc++;
    if (chan_closed !== pc) n++;
    pc = chan_closed;
    if (cyc > 80000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : tick
  task automatic kick(input int w);
    case (w)
      0: key = 1'h1;
      1: initiate_command = 1'h1;
      2: continuous_initiate_command = 1'h1;
      default: open_all = 1'h1;
    endcase
    tick(1);
    {key, initiate_command, continuous_initiate_command, open_all} = '0;
  endtask : kick
  task automatic fire(input sts_pkg::sts_spacing_t s);
    src = s;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    tick(1);
  endtask : fire
  // Bounded wait so a sequencer stuck in a layer is caught, not hung on.
  task automatic fin;
    for (int k = 0; k < 300 && armed !== 1'h0; k++) tick(1);
  endtask : fin
  task automatic end_of_test;
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    {key, initiate_command, continuous_initiate_command, open_all, go} = '0;
    {arm_infinite, scan_infinite, chan_infinite, rst, chan_use_list} = 5'h3;
    {arm_spacing, scan_spacing, chan_spacing, src} = '0;
    {arm_count, scan_count, chan_count} = {14'h0001, 14'h0001, 14'h0001};
    {list_len, timer_ms, settle_ms} = {6'h02, 27'h0000001, 27'h0000000};
    {fails, compares, cyc} = '0;
    tick(2);
    rst = 1'h0;
    chk(armed, 1'h0);
    chk({chan_valid, chan_closed, open_all_pulse, cfg_error}, '0);
    timer_ms = 27'h0000000;
    tick(1);
    chk(cfg_error, 1'h1);
    timer_ms = 27'h0000001;
    tick(1);
    n = 0;
    kick(0);
    fin;
    chk({armed, n[6:0]}, 8'h02);
    chk(chan_closed, 6'h02);
    {arm_count, scan_count, n} = {14'h0002, 14'h0003, 32'h0};
    kick(1);
    fin;
    chk({armed, n[6:0]}, 8'h0C);
    {arm_count, scan_count, n} = {14'h0001, 14'h0001, 32'h0};
    scan_spacing = sts_pkg::STS_SP_TIMER;
    kick(2);
    fin;
    chk({armed, n[6:0]}, 8'h02);
    {scan_count, n} = {14'h0002, 32'h0};
    kick(2);
    tick(20);
    chk({armed, n[6:0]}, 8'h82);
    tick(50000);
    chk({armed, n[6:0]}, 8'h04);
    scan_count = 14'h0001;
    for (int l = 0; l < 3; l++) for (int s = 2; s < 6; s++) begin
      sp = sts_pkg::sts_spacing_t'(s);
      arm_spacing = (l == 0) ? sp : sts_pkg::STS_SP_IMMED;
      scan_spacing = (l == 1) ? sp : sts_pkg::STS_SP_IMMED;
      chan_spacing = (l == 2) ? sp : sts_pkg::STS_SP_IMMED;
      kick(1);
      fire(sp == sts_pkg::STS_SP_BUS ? sts_pkg::STS_SP_EXT : sts_pkg::STS_SP_BUS);
      tick(4);
      chk(armed, 1'h1);
      fire(sp);
      if (l == 2) begin
        tick(3);
        chk(armed, 1'h1);
        fire(sp);
      end
      fin;
      chk(armed, 1'h0);
    end
    {arm_spacing, scan_spacing} = '0;
    chan_spacing = sts_pkg::STS_SP_MAN;
    {chan_use_list, chan_infinite} = 2'h1;
    kick(2);
    tick(3);
    fire(sts_pkg::STS_SP_MAN);
    tick(2);
    c1 = chan_closed;
    fire(sts_pkg::STS_SP_MAN);
    tick(2);
    chk(chan_closed, c1 == 6'h01 ? 6'h02 : 6'h01);
    fire(sts_pkg::STS_SP_MAN);
    tick(2);
    chk({armed, chan_closed}, {1'h1, c1});
    kick(3);
    chk({open_all_pulse, armed, chan_valid}, 3'h4);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
